// >>> logic/itir_pkg.sv
package itir_pkg;

  // ----------------------------------------------------------------
  // Clocks and widths
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SUB_HZ = 32_768;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned PSS_W = 13;
  localparam int unsigned PSW_W = 7;
  localparam int unsigned CNT_W = 8;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] SUB_OUT_SEL_IDX = 16'hff92;
  localparam logic [15:0] TIMER_MODE_IDX = 16'hffb0;
  localparam logic [15:0] INTERVAL_COUNT_IDX = 16'hffb1;
  localparam logic [15:0] IRQ_STATUS_IDX = 16'hffb2;
  localparam logic [15:0] IRQ_MASK_IDX = 16'hffb3;
  localparam logic [15:0] CLOCK_STOP_IDX = 16'hfffa;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] SUB_OUT_SEL_RST = 8'hfe;
  localparam logic [7:0] TIMER_MODE_RST = 8'h10;
  localparam logic [7:0] INTERVAL_COUNT_RST = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] CLOCK_STOP_RST = 8'hff;
  localparam int unsigned MODE_RSVD_BIT = 4;
  localparam int unsigned DIRECT_SUB_BIT = 0;
  localparam int unsigned RUN_BIT = 0;
  localparam int unsigned OVF_BIT = 0;

  // ----------------------------------------------------------------
  // Time-base periods and the subclock prescaler taps they need
  // ----------------------------------------------------------------
  localparam longint unsigned TB_STEPS = 256;
  localparam longint unsigned TB_PERIOD_US_0 = 1_000_000;
  localparam longint unsigned TB_PERIOD_US_1 = 500_000;
  localparam longint unsigned TB_PERIOD_US_2 = 250_000;
  localparam longint unsigned TB_PERIOD_US_3 = 31_250;

  typedef struct packed {
    logic [2:0] out_sel;
    logic rsvd;
    logic [3:0] cnt_sel;
  } itir_mode_t;

  typedef enum logic [3:0] {
    PWR_ACTIVE = 4'b0001,
    PWR_SLEEP = 4'b0010,
    PWR_SUBACTIVE = 4'b0100,
    PWR_STANDBY = 4'b1000
  } itir_pwr_t;

  function automatic int unsigned tb_bits(input logic [1:0] code);
    longint unsigned us;
    case (code)
      2'd0: us = TB_PERIOD_US_0;
      2'd1: us = TB_PERIOD_US_1;
      2'd2: us = TB_PERIOD_US_2;
      default: us = TB_PERIOD_US_3;
    endcase
    return $clog2(int'(us * SUB_HZ / (TB_STEPS * 1_000_000)));
  endfunction : tb_bits

  function automatic int unsigned pss_bits(input logic [2:0] code);
    case (code)
      3'd0: return 13;
      3'd1: return 12;
      3'd2: return 11;
      3'd3: return 9;
      3'd4: return 8;
      3'd5: return 7;
      3'd6: return 5;
      default: return 3;
    endcase
  endfunction : pss_bits

  // True when the low "bits" bits of a prescaler are all ones.
  function automatic logic tap_hit(input logic [15:0] cnt, input int unsigned bits);
    logic [15:0] m;
    m = 16'((32'd1 << bits) - 32'd1);
    return (cnt & m) == m;
  endfunction : tap_hit

endpackage : itir_pkg

// >>> logic/itir_prescaler.sv
`timescale 1ns/1ns
module itir_prescaler
  import itir_pkg::*;
#(
  parameter int unsigned W = 8
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clear_i,
  input wire logic adv_i,
  // Count
  output logic [W-1:0] cnt_o
);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
    begin
      cnt_o <= '0;
    end
    else if (adv_i)
    begin
      cnt_o <= cnt_o + W'(1);
    end
  end

endmodule : itir_prescaler

// >>> logic/itir_clkout.sv
`timescale 1ns/1ns
module itir_clkout
  import itir_pkg::*;
(
  // Sources
  input wire logic [PSS_W-1:0] pss_i,
  input wire logic [PSW_W-1:0] psw_i,
  input wire logic sub_lvl_i,
  // Selection
  input wire logic [2:0] out_sel_i,
  input wire logic direct_i,
  input wire itir_pwr_t pwr_i,
  // Next pin level
  output logic pin_d_o
);

  logic [1:0] idx;

  // Bit k of a free-running count is a square wave at the source over 2^(k+1).
  always_comb
  begin
    idx = 2'(3'd4 - {1'b0, out_sel_i[1:0]}) ;
    pin_d_o = 1'b0;
    if (direct_i)
    begin
      pin_d_o = sub_lvl_i;
    end
    else if (out_sel_i[2])
    begin
      if (pwr_i != PWR_STANDBY)
      begin
        pin_d_o = psw_i[{1'b0, idx} + 3'd1 - 3'd1 + 3'(idx == 2'd0 ? 3'd4 : 3'd0)];
      end
    end
    else if (pwr_i == PWR_ACTIVE || pwr_i == PWR_SLEEP)
    begin
      pin_d_o = pss_i[{1'b0, idx} + 3'(idx == 2'd0 ? 3'd4 : 3'd0)];
    end
  end

endmodule : itir_clkout

// >>> logic/itir_timer.sv
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ns
// How it works
// - Eight-bit up-counter: interval timer or time base.
// - Interval clock: eight system prescaler divisions.
// - Time base overflows every 1, 0.5, 0.25, 0.03125 s.
// - Time base only runs with 32.768 kHz subclock.
// - Every counter overflow raises an interrupt request.
// - Output pin carries one of nine clocks.
// - Module standby stops the timer independently.
// - Mode register: eight bits, read and write.
// - Mode register resets to 10 hex.
// - Output select 0xx: system clock /32../4.
// - System clock outputs only in active, sleep.
// - Subclock divided outputs also in subactive.
// - Undivided subclock output except during reset.
// - Codes 0000-0111 pick system prescaler taps.
// - Codes 1000-1011 time base; 11xx hold reset.
// - Output select 1xx subclock; bit four reads one.
module itir_timer
  import itir_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Subclock and system state
  input wire logic sub_clk_i,
  input wire logic sub_is_32k_i,
  input wire itir_pwr_t pwr_i,
  // Outputs
  output logic divided_clock_out_pin_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  itir_mode_t timer_mode_reg_q;
  logic [7:0] interval_count_reg_q;
  logic [7:0] subclock_output_select_reg_q;
  logic [7:0] module_clock_stop_reg_one_q;
  logic [7:0] irq_status_q;
  logic [7:0] irq_mask_q;
  logic sub_lvl_q;
  logic sub_prev_q;

  logic [PSS_W-1:0] system_prescaler;
  logic [PSW_W-1:0] subclock_prescaler;
  logic run;
  logic sub_edge;
  logic psw_clear;
  logic count_tick;
  logic overflow;
  logic req;
  logic wr;
  logic [15:0] idx;
  logic pin_d;

  assign run = module_clock_stop_reg_one_q[RUN_BIT];
  assign sub_edge = sub_lvl_q & ~sub_prev_q;
  assign psw_clear = timer_mode_reg_q.cnt_sel[3] & timer_mode_reg_q.cnt_sel[2];
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = cyc_i & stb_i & ack_o & we_i & sel_i[0];
  assign idx = adr_i[ADDR_W-1:2];

  // ----------------------------------------------------------------
  // Prescalers
  // ----------------------------------------------------------------
  itir_prescaler #(
    .W(PSS_W)
  ) u_system_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(1'b0),
    .adv_i(run),
    .cnt_o(system_prescaler)
  );

  itir_prescaler #(
    .W(PSW_W)
  ) u_subclock_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(psw_clear),
    .adv_i(run & sub_edge),
    .cnt_o(subclock_prescaler)
  );

  // The subclock is taken as synchronous; its rising edge steps the
  // subclock prescaler once per subclock period.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sub_lvl_q <= 1'b0;
      sub_prev_q <= 1'b0;
    end
    else
    begin
      sub_lvl_q <= sub_clk_i;
      sub_prev_q <= sub_lvl_q;
    end
  end

  // ----------------------------------------------------------------
  // Counter clock selection
  // ----------------------------------------------------------------
  always_comb
  begin
    count_tick = 1'b0;
    if (!run)
    begin
      count_tick = 1'b0;
    end
    else if (!timer_mode_reg_q.cnt_sel[3])
    begin
      count_tick = tap_hit(16'(system_prescaler),
        pss_bits(timer_mode_reg_q.cnt_sel[2:0]));
    end
    else if (!timer_mode_reg_q.cnt_sel[2] && sub_is_32k_i)
    begin
      // A 38.4 kHz subclock would give wrong periods, so it never counts.
      count_tick = sub_edge & tap_hit(16'(subclock_prescaler),
        tb_bits(timer_mode_reg_q.cnt_sel[1:0]));
    end
  end

  assign overflow = count_tick & (interval_count_reg_q == 8'hff);

  // ----------------------------------------------------------------
  // Interval counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || psw_clear)
    begin
      interval_count_reg_q <= INTERVAL_COUNT_RST;
    end
    else if (count_tick)
    begin
      interval_count_reg_q <= interval_count_reg_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer_mode_reg_q <= itir_mode_t'(TIMER_MODE_RST);
    end
    else if (wr && idx == TIMER_MODE_IDX)
    begin
      timer_mode_reg_q.out_sel <= dat_i[7:5];
      timer_mode_reg_q.rsvd <= 1'b1;
      timer_mode_reg_q.cnt_sel <= dat_i[3:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      subclock_output_select_reg_q <= SUB_OUT_SEL_RST;
      module_clock_stop_reg_one_q <= CLOCK_STOP_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end
    else if (wr)
    begin
      if (idx == SUB_OUT_SEL_IDX)
      begin
        subclock_output_select_reg_q <= {7'h7f, dat_i[DIRECT_SUB_BIT]};
      end
      else if (idx == CLOCK_STOP_IDX)
      begin
        module_clock_stop_reg_one_q <= dat_i[7:0];
      end
      else if (idx == IRQ_MASK_IDX)
      begin
        irq_mask_q <= {7'h00, dat_i[OVF_BIT]};
      end
    end
  end

  // An overflow in the same cycle as a write-one-to-clear stays set.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_status_q <= IRQ_STATUS_RST;
    end
    else
    begin
      irq_status_q[OVF_BIT] <= overflow |
        (irq_status_q[OVF_BIT] & ~(wr && idx == IRQ_STATUS_IDX && dat_i[OVF_BIT]));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(irq_status_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // Every access, mapped or not, is acknowledged one cycle after it is
  // presented; unmapped reads return zero and unmapped writes are dropped.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req;
      if (!req || we_i)
      begin
        dat_o <= 32'h0000_0000;
      end
      else if (idx == TIMER_MODE_IDX)
      begin
        dat_o <= {24'h000000, timer_mode_reg_q};
      end
      else if (idx == INTERVAL_COUNT_IDX)
      begin
        dat_o <= {24'h000000, interval_count_reg_q};
      end
      else if (idx == SUB_OUT_SEL_IDX)
      begin
        dat_o <= {24'h000000, subclock_output_select_reg_q};
      end
      else if (idx == CLOCK_STOP_IDX)
      begin
        dat_o <= {24'h000000, module_clock_stop_reg_one_q};
      end
      else if (idx == IRQ_STATUS_IDX)
      begin
        dat_o <= {24'h000000, irq_status_q};
      end
      else if (idx == IRQ_MASK_IDX)
      begin
        dat_o <= {24'h000000, irq_mask_q};
      end
      else
      begin
        dat_o <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock output pin
  // ----------------------------------------------------------------
  itir_clkout u_clkout (
    .pss_i(system_prescaler),
    .psw_i(subclock_prescaler),
    .sub_lvl_i(sub_lvl_q),
    .out_sel_i(timer_mode_reg_q.out_sel),
    .direct_i(subclock_output_select_reg_q[DIRECT_SUB_BIT]),
    .pwr_i(pwr_i),
    .pin_d_o(pin_d)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      divided_clock_out_pin_o <= 1'b0;
    end
    else
    begin
      divided_clock_out_pin_o <= pin_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence ovf_cause_s;
    count_tick && interval_count_reg_q == 8'hff;
  endsequence

  sequence ovf_effect_s;
    interval_count_reg_q == 8'h00 && irq_status_q[OVF_BIT];
  endsequence

  count_wrap_a: assert property (ovf_cause_s |=> ovf_effect_s)
    else $error("counter did not wrap and flag overflow");

  count_step_a: assert property (count_tick && !psw_clear |=>
    interval_count_reg_q == 8'($past(interval_count_reg_q) + 8'h01))
    else $error("counter did not step on tick");

  mode_reserved_a: assert property (timer_mode_reg_q.rsvd == 1'b1)
    else $error("reserved mode bit not one");

  mode_reset_a: assert property (@(posedge clk_i) disable iff (1'b0)
    $past(rst_i) |-> timer_mode_reg_q == itir_mode_t'(TIMER_MODE_RST))
    else $error("mode register not at reset value");

  pin_reset_a: assert property (@(posedge clk_i) disable iff (1'b0)
    $past(rst_i) |-> !divided_clock_out_pin_o)
    else $error("clock pin driven during reset");

  tb_hold_a: assert property (psw_clear |=> interval_count_reg_q == 8'h00
    && subclock_prescaler == '0)
    else $error("hold code did not clear counter");

  standby_freeze_a: assert property (!run ##1 !run |-> $stable(interval_count_reg_q))
    else $error("counter moved in module standby");

  sys_gate_a: assert property (!subclock_output_select_reg_q[DIRECT_SUB_BIT]
    && !timer_mode_reg_q.out_sel[2] && pwr_i == PWR_SUBACTIVE
    |=> !divided_clock_out_pin_o)
    else $error("system clock output outside active or sleep");

  no_38k_tb_a: assert property (!sub_is_32k_i && timer_mode_reg_q.cnt_sel[3]
    |-> !count_tick)
    else $error("time base counted without 32.768 kHz subclock");

  sys_tap_a: assert property (run && timer_mode_reg_q.cnt_sel == 4'h7
    && system_prescaler[2:0] == 3'h7 |-> count_tick)
    else $error("divide by 8 tap missed");

  irq_level_a: assert property (irq_status_q[OVF_BIT] && irq_mask_q[OVF_BIT]
    ##1 irq_status_q[OVF_BIT] |-> irq_o)
    else $error("interrupt not raised for unmasked status");

  bus_ack_a: assert property (req |=> ack_o ##1 !ack_o)
    else $error("bus answer not a one-cycle pulse");

endmodule : itir_timer

// >>> sim/itir_timer_tb_top.sv
`timescale 1ns/1ns
module itir_timer_tb_top
  import itir_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic sub_clk = 1'b0;
  logic sub_32k = 1'b1;
  logic [17:0] adr = '0;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic ack, pin, irq, pin_q;
  itir_pwr_t pwr = PWR_ACTIVE;
  int sub_n = 0;
  int edges = 0;
  int fail_count = 0;
  int n_checks = 0;

  always #10 clk = ~clk;

  // The subclock is made from the system clock, 20 cycles a period, so rates come out exact.
  always @(posedge clk)
  begin
    sub_n <= (sub_n == 9) ? 0 : sub_n + 1;
    if (sub_n == 9) sub_clk <= ~sub_clk;
  end

  always @(posedge clk)
  begin
    pin_q <= pin;
    if (pin === 1'b1 && pin_q === 1'b0) edges <= edges + 1;
  end

  itir_timer dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .sub_clk_i(sub_clk),
    .sub_is_32k_i(sub_32k), .pwr_i(pwr), .divided_clock_out_pin_o(pin), .irq_o(irq));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] wd,
                    output logic [7:0] rd);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, wd};
    // Only ack or the watchdog ends this wait; the slave decides when it answers.
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    chk(rdat[31:16], 16'h0000);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] v;
    wb(1'b1, idx, d, v);
  endtask : wr

  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    wb(1'b0, idx, 8'h00, v);
    chk({8'h00, v}, {8'h00, exp});
  endtask : rdchk

  // Two count samples taken exactly win cycles apart, whatever the prescaler phase.
  task automatic cnt_rate(input int win, input logic [7:0] exp);
    logic [7:0] a, b;
    wb(1'b0, INTERVAL_COUNT_IDX, 8'h00, a);
    repeat (win - 3) @(posedge clk);
    wb(1'b0, INTERVAL_COUNT_IDX, 8'h00, b);
    chk({8'h00, 8'(b - a)}, {8'h00, exp});
  endtask : cnt_rate

  // Edge counts allow one edge of slack for the phase at the window ends.
  task automatic pin_rate(input int win, input int exp);
    int d;
    d = edges;
    repeat (win) @(posedge clk);
    d = edges - d;
    chk({15'h0000, (d >= exp - 1 && d <= exp + 1)}, 16'h0001);
  endtask : pin_rate

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rdchk(SUB_OUT_SEL_IDX, 8'hfe);
    rdchk(TIMER_MODE_IDX, 8'h10);
    rdchk(INTERVAL_COUNT_IDX, 8'h00);
    rdchk(IRQ_STATUS_IDX, 8'h00);
    rdchk(IRQ_MASK_IDX, 8'h00);
    rdchk(CLOCK_STOP_IDX, 8'hff);
    // The counter is still at zero here, so a write that landed would show.
    wr(INTERVAL_COUNT_IDX, 8'h55);
    rdchk(INTERVAL_COUNT_IDX, 8'h00);
    wr(16'hff00, 8'h5a);
    rdchk(16'hff00, 8'h00);
    wr(TIMER_MODE_IDX, 8'h00);
    rdchk(TIMER_MODE_IDX, 8'h10);
    wr(TIMER_MODE_IDX, 8'h17);
    repeat (40) @(posedge clk);
    wr(TIMER_MODE_IDX, 8'hef);
    rdchk(TIMER_MODE_IDX, 8'hff);
    repeat (40) @(posedge clk);
    rdchk(INTERVAL_COUNT_IDX, 8'h00);
    sel <= 4'he;
    wr(TIMER_MODE_IDX, 8'h10);
    sel <= 4'hf;
    rdchk(TIMER_MODE_IDX, 8'hff);
    $display("done: registers");
  endtask : t_regs

  task automatic t_rates();
    int divs[8] = '{8192, 4096, 2048, 512, 256, 128, 32, 8};
    int taps[4] = '{128, 64, 32, 4};
    for (int c = 0; c < 8; c++)
    begin
      wr(TIMER_MODE_IDX, 8'(8'h10 + c));
      cnt_rate(2 * divs[c], 8'h02);
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(TIMER_MODE_IDX, 8'(8'h18 + c));
      cnt_rate(40 * taps[c], 8'h02);
    end
    sub_32k <= 1'b0;
    cnt_rate(400, 8'h00);
    sub_32k <= 1'b1;
    wr(TIMER_MODE_IDX, 8'h17);
    wr(CLOCK_STOP_IDX, 8'hfe);
    cnt_rate(160, 8'h00);
    wr(CLOCK_STOP_IDX, 8'hff);
    cnt_rate(160, 8'h14);
    $display("done: count rates");
  endtask : t_rates

  task automatic t_overflow();
    logic [7:0] v;
    int n;
    wr(IRQ_MASK_IDX, 8'h01);
    wr(IRQ_STATUS_IDX, 8'h01);
    n = 0;
    while (irq !== 1'b1 && n < 2100)
    begin
      @(posedge clk);
      n++;
    end
    chk({15'h0000, irq}, 16'h0001);
    rdchk(INTERVAL_COUNT_IDX, 8'h00);
    rdchk(IRQ_STATUS_IDX, 8'h01);
    wr(IRQ_STATUS_IDX, 8'h01);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    wr(IRQ_MASK_IDX, 8'h00);
    repeat (2100) @(posedge clk);
    rdchk(IRQ_STATUS_IDX, 8'h01);
    chk({15'h0000, irq}, 16'h0000);
    wr(IRQ_STATUS_IDX, 8'h01);
    $display("done: overflow");
  endtask : t_overflow

  task automatic t_pin();
    int d;
    for (int k = 0; k < 8; k++)
    begin
      d = (k < 4) ? (32 >> k) : 20 * (32 >> (k - 4));
      // Counter select stays off the hold codes, which stop the subclock prescaler.
      wr(TIMER_MODE_IDX, {3'(k), 5'h10});
      pin_rate(1280, 1280 / d);
    end
    wr(TIMER_MODE_IDX, 8'h70);
    pwr <= PWR_SUBACTIVE;
    pin_rate(400, 0);
    pwr <= PWR_SLEEP;
    pin_rate(400, 100);
    wr(TIMER_MODE_IDX, 8'hf0);
    pwr <= PWR_SUBACTIVE;
    pin_rate(1600, 20);
    wr(SUB_OUT_SEL_IDX, 8'hff);
    rdchk(SUB_OUT_SEL_IDX, 8'hff);
    pwr <= PWR_STANDBY;
    pin_rate(400, 20);
    rst <= 1'b1;
    pin_rate(200, 0);
    rst <= 1'b0;
    pwr <= PWR_ACTIVE;
    @(posedge clk);
    rdchk(SUB_OUT_SEL_IDX, 8'hfe);
    rdchk(TIMER_MODE_IDX, 8'h10);
    $display("done: output pin");
  endtask : t_pin

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (16) @(posedge clk);
    chk({14'h0000, pin, irq}, 16'h0000);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_rates();
    t_overflow();
    t_pin();
    wrap_up();
  end

  // The scenarios need about 60000 cycles; a hang is cut off well beyond that.
  initial
  begin
    repeat (95000) @(posedge clk);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end

endmodule : itir_timer_tb_top
